//--- design/dtc_pkg.sv
/*
 Shared constants of the dual timer/counter block: register indices, field
 positions, mode codes and reset values. Assumes a 32-bit AXI4-Lite master.
*/
`default_nettype none
package dtc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_TIMER_CONTROL = 10'h088;
    localparam logic [9:0] IDX_TIMER_MODE    = 10'h089;
    localparam logic [9:0] IDX_TIMER0_LOW    = 10'h08A;
    localparam logic [9:0] IDX_TIMER1_LOW    = 10'h08B;
    localparam logic [9:0] IDX_TIMER0_HIGH   = 10'h08C;
    localparam logic [9:0] IDX_TIMER1_HIGH   = 10'h08D;
    localparam logic [9:0] IDX_IRQ_STATUS    = 10'h0A0;
    localparam logic [9:0] IDX_IRQ_MASK      = 10'h0A1;
    localparam int MIN_ADDR_W = 12;

    // timer_control fields
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;

    // timer_mode fields
    localparam int TM_TIMER1_GATING_SEL = 7;
    localparam int TM_SRC1  = 6;
    localparam int TM_MODE1 = 4;
    localparam int TM_TIMER0_GATING_SEL = 3;
    localparam int TM_SRC0  = 2;
    localparam int TM_MODE0 = 0;

    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'b00,
        DTC_MODE_16BIT    = 2'b01,
        DTC_MODE_RELOAD   = 2'b10,
        DTC_MODE_SPLIT    = 2'b11
    } dtc_mode_e;

    // irq_status / irq_mask bit positions
    localparam int ST_TF0 = 0;
    localparam int ST_TF1 = 1;
    localparam int ST_IE0 = 2;
    localparam int ST_IE1 = 3;
    localparam int ST_W   = 4;

    localparam logic [7:0]      RST_BYTE   = 8'h00;
    localparam logic [ST_W-1:0] RST_STATUS = 4'h0;
    localparam logic [ST_W-1:0] RST_MASK   = 4'h0;

    // timer mode advances once per this many system clocks
    localparam int CYCLES_PER_TICK = 2;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

//--- design/dtc_timer_top.sv
/*
 Two 8/16-bit timer/counters with the two external interrupt detectors,
 behind an AXI4-Lite slave. Assumes pins are asynchronous, vector acks come
 from the CPU on aclk as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,             // system clock
    input  wire logic              aresetn,          // sync reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,           // write address
    input  wire logic [2:0]        awprot,           // unused
    input  wire logic              awvalid,          // write address valid
    output logic                   awready,          // write address ready
    input  wire logic [31:0]       wdata,            // write data
    input  wire logic [3:0]        wstrb,            // byte enables
    input  wire logic              wvalid,           // write data valid
    output logic                   wready,           // write data ready
    output logic [1:0]             bresp,            // write response
    output logic                   bvalid,           // write response valid
    input  wire logic              bready,           // write response ready
    input  wire logic [ADDR_W-1:0] araddr,           // read address
    input  wire logic [2:0]        arprot,           // unused
    input  wire logic              arvalid,          // read address valid
    output logic                   arready,          // read address ready
    output logic [31:0]            rdata,            // read data
    output logic [1:0]             rresp,            // read response
    output logic                   rvalid,           // read data valid
    input  wire logic              rready,           // read data ready
    input  wire logic              ext_irq0_pin,     // external interrupt 0
    input  wire logic              ext_irq1_pin,     // external interrupt 1
    input  wire logic              timer0_count_pin, // timer0 event input
    input  wire logic              timer1_count_pin, // timer1 event input
    input  wire logic              ack_timer0,       // cpu vectored timer0
    input  wire logic              ack_timer1,       // cpu vectored timer1
    input  wire logic              ack_ext_irq0,     // cpu vectored ext irq0
    input  wire logic              ack_ext_irq1,     // cpu vectored ext irq1
    output logic                   timer0_overflow_flag, // pending timer0
    output logic                   timer1_overflow_flag, // pending timer1
    output logic                   ext_irq0_flag,    // pending ext irq0
    output logic                   ext_irq1_flag,    // pending ext irq1
    output logic                   irq               // masked status level
);
    generate
        if (ADDR_W < dtc_pkg::MIN_ADDR_W) begin : g_chk
            $error("ADDR_W too small for register map");
        end
    endgenerate

    // pin synchronisers: index 0 irq0, 1 irq1, 2 count0, 3 count1
    logic [3:0] pin_in;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] pin_prev_reg;
    logic [3:0] pin_fall;
    assign pin_in = {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_meta_reg[gi] <= 1'b1;
                    pin_sync_reg[gi] <= 1'b1;
                    pin_prev_reg[gi] <= 1'b1;
                end else begin
                    pin_meta_reg[gi] <= pin_in[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    pin_prev_reg[gi] <= pin_sync_reg[gi];
                end
            end
            assign pin_fall[gi] = pin_prev_reg[gi] & ~pin_sync_reg[gi];
        end
    endgenerate

    // one-cycle tick every CYCLES_PER_TICK clocks
    localparam int TICK_W = $clog2(dtc_pkg::CYCLES_PER_TICK);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(dtc_pkg::CYCLES_PER_TICK - 1);
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
        end
    end
    assign tick = (tick_cnt_reg == TICK_LAST);

    logic [7:0] control_reg;
    logic [7:0] mode_reg;
    logic [7:0] tl0_reg;
    logic [7:0] th0_reg;
    logic [7:0] tl1_reg;
    logic [7:0] th1_reg;
    logic [dtc_pkg::ST_W-1:0] status_reg;
    logic [dtc_pkg::ST_W-1:0] mask_reg;

    dtc_pkg::dtc_mode_e mode0;
    dtc_pkg::dtc_mode_e mode1;
    assign mode0 = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::TM_MODE0 +: 2]);
    assign mode1 = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::TM_MODE1 +: 2]);

    // one count step for modes 00/01/10: {overflow, high, low}
    function automatic logic [16:0] dtc_step(input dtc_pkg::dtc_mode_e m,
                                             input logic [7:0] th,
                                             input logic [7:0] tl);
        logic [5:0]  low5;
        logic [8:0]  hi;
        logic [16:0] s16;
        logic [8:0]  s8;
        low5 = {1'b0, tl[4:0]} + 6'h01;
        hi   = {1'b0, th} + {8'h00, low5[5]};
        s16  = {1'b0, th, tl} + 17'h00001;
        s8   = {1'b0, tl} + 9'h001;
        case (m)
            dtc_pkg::DTC_MODE_PRESCALE: dtc_step = {hi, tl[7:5], low5[4:0]};
            dtc_pkg::DTC_MODE_16BIT:    dtc_step = s16;
            dtc_pkg::DTC_MODE_RELOAD:   dtc_step = {s8[8], th, s8[8] ? th : s8[7:0]};
            default:                    dtc_step = {1'b0, th, tl};
        endcase
    endfunction

    logic       t0_en;
    logic       t1_en;
    logic       th0_split_en;
    logic [7:0] tl0_next;
    logic [7:0] th0_next;
    logic [7:0] tl1_next;
    logic [7:0] th1_next;
    logic       ovf0;
    logic       ovf1;
    logic       ovf_th0;
    logic       tf0_set;
    logic       tf1_set;
    logic       ie0_set;
    logic       ie1_set;

    always_comb begin
        t0_en = control_reg[dtc_pkg::TC_TR0]
              & (~mode_reg[dtc_pkg::TM_TIMER0_GATING_SEL] | pin_sync_reg[0])
              & (mode_reg[dtc_pkg::TM_SRC0] ? pin_fall[2] : tick);
        t1_en = control_reg[dtc_pkg::TC_TR1]
              & (~mode_reg[dtc_pkg::TM_TIMER1_GATING_SEL] | pin_sync_reg[1])
              & (mode_reg[dtc_pkg::TM_SRC1] ? pin_fall[3] : tick);
        th0_split_en = control_reg[dtc_pkg::TC_TR1] & tick;
        tl0_next = tl0_reg;
        th0_next = th0_reg;
        tl1_next = tl1_reg;
        th1_next = th1_reg;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        ovf_th0 = 1'b0;
        if (mode0 == dtc_pkg::DTC_MODE_SPLIT) begin
            if (t0_en) begin
                {ovf0, tl0_next} = {1'b0, tl0_reg} + 9'h001;
            end
            if (th0_split_en) begin
                {ovf_th0, th0_next} = {1'b0, th0_reg} + 9'h001;
            end
        end else if (t0_en) begin
            {ovf0, th0_next, tl0_next} = dtc_step(mode0, th0_reg, tl0_reg);
        end
        // mode 11 of timer1 holds it
        if (mode1 != dtc_pkg::DTC_MODE_SPLIT && t1_en) begin
            {ovf1, th1_next, tl1_next} = dtc_step(mode1, th1_reg, tl1_reg);
        end
        tf0_set = ovf0;
        // split high byte takes over timer1's flag
        tf1_set = (mode0 == dtc_pkg::DTC_MODE_SPLIT) ? ovf_th0 : ovf1;
        ie0_set = control_reg[dtc_pkg::TC_IT0] ? pin_fall[0] : ~pin_sync_reg[0];
        ie1_set = control_reg[dtc_pkg::TC_IT1] ? pin_fall[1] : ~pin_sync_reg[1];
    end

    // AXI4-Lite write path: address and data latched independently
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [9:0]        aw_idx_reg;
    logic [7:0]        w_byte_reg;
    logic              w_lane_reg;
    logic              wr_fire;
    logic              wr_en;
    logic              ar_fire;
    logic [9:0]        ar_idx;

    assign awready = ~aw_held_reg & ~bvalid;
    assign wready  = ~w_held_reg & ~bvalid;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid;
    assign wr_en   = wr_fire & w_lane_reg;
    assign arready = ~rvalid;
    assign ar_fire = arvalid & arready;
    assign ar_idx  = araddr[11:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= awaddr[11:2];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            w_byte_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    function automatic logic dtc_mapped(input logic [9:0] idx);
        dtc_mapped = (idx >= dtc_pkg::IDX_TIMER_CONTROL && idx <= dtc_pkg::IDX_TIMER1_HIGH)
                   || idx == dtc_pkg::IDX_IRQ_STATUS || idx == dtc_pkg::IDX_IRQ_MASK;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= dtc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= dtc_mapped(aw_idx_reg) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    logic wr_ctl;
    assign wr_ctl = wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER_CONTROL;

    // flags: hardware set beats both ack and software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg <= dtc_pkg::RST_BYTE;
        end else begin
            if (wr_ctl) begin
                control_reg[dtc_pkg::TC_TR1] <= w_byte_reg[dtc_pkg::TC_TR1];
                control_reg[dtc_pkg::TC_TR0] <= w_byte_reg[dtc_pkg::TC_TR0];
                control_reg[dtc_pkg::TC_IT1] <= w_byte_reg[dtc_pkg::TC_IT1];
                control_reg[dtc_pkg::TC_IT0] <= w_byte_reg[dtc_pkg::TC_IT0];
            end
            if (tf1_set)
                control_reg[dtc_pkg::TC_TF1] <= 1'b1;
            else if (ack_timer1)
                control_reg[dtc_pkg::TC_TF1] <= 1'b0;
            else if (wr_ctl)
                control_reg[dtc_pkg::TC_TF1] <= w_byte_reg[dtc_pkg::TC_TF1];
            if (tf0_set)
                control_reg[dtc_pkg::TC_TF0] <= 1'b1;
            else if (ack_timer0)
                control_reg[dtc_pkg::TC_TF0] <= 1'b0;
            else if (wr_ctl)
                control_reg[dtc_pkg::TC_TF0] <= w_byte_reg[dtc_pkg::TC_TF0];
            if (ie1_set)
                control_reg[dtc_pkg::TC_IE1] <= 1'b1;
            else if (ack_ext_irq1)
                control_reg[dtc_pkg::TC_IE1] <= 1'b0;
            else if (wr_ctl)
                control_reg[dtc_pkg::TC_IE1] <= w_byte_reg[dtc_pkg::TC_IE1];
            if (ie0_set)
                control_reg[dtc_pkg::TC_IE0] <= 1'b1;
            else if (ack_ext_irq0)
                control_reg[dtc_pkg::TC_IE0] <= 1'b0;
            else if (wr_ctl)
                control_reg[dtc_pkg::TC_IE0] <= w_byte_reg[dtc_pkg::TC_IE0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            mode_reg <= dtc_pkg::RST_BYTE;
        else if (wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER_MODE)
            mode_reg <= w_byte_reg;
    end

    // a software write overrides the count step of that cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tl0_reg <= dtc_pkg::RST_BYTE;
            th0_reg <= dtc_pkg::RST_BYTE;
            tl1_reg <= dtc_pkg::RST_BYTE;
            th1_reg <= dtc_pkg::RST_BYTE;
        end else begin
            tl0_reg <= (wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER0_LOW)  ? w_byte_reg : tl0_next;
            th0_reg <= (wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER0_HIGH) ? w_byte_reg : th0_next;
            tl1_reg <= (wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER1_LOW)  ? w_byte_reg : tl1_next;
            th1_reg <= (wr_en && aw_idx_reg == dtc_pkg::IDX_TIMER1_HIGH) ? w_byte_reg : th1_next;
        end
    end

    // sticky status, cleared by a read; new events win over the clear
    logic [dtc_pkg::ST_W-1:0] events;
    logic                     st_rd;
    assign events = {ie1_set, ie0_set, tf1_set, tf0_set};
    assign st_rd  = ar_fire && ar_idx == dtc_pkg::IDX_IRQ_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            status_reg <= dtc_pkg::RST_STATUS;
        else
            status_reg <= (st_rd ? dtc_pkg::RST_STATUS : status_reg) | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            mask_reg <= dtc_pkg::RST_MASK;
        else if (wr_en && aw_idx_reg == dtc_pkg::IDX_IRQ_MASK)
            mask_reg <= w_byte_reg[dtc_pkg::ST_W-1:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    // read path; data is captured when the address is taken
    logic [7:0] rd_byte;
    always_comb begin
        case (ar_idx)
            dtc_pkg::IDX_TIMER_CONTROL: rd_byte = control_reg;
            dtc_pkg::IDX_TIMER_MODE:    rd_byte = mode_reg;
            dtc_pkg::IDX_TIMER0_LOW:    rd_byte = tl0_reg;
            dtc_pkg::IDX_TIMER1_LOW:    rd_byte = tl1_reg;
            dtc_pkg::IDX_TIMER0_HIGH:   rd_byte = th0_reg;
            dtc_pkg::IDX_TIMER1_HIGH:   rd_byte = th1_reg;
            dtc_pkg::IDX_IRQ_STATUS:    rd_byte = {4'h0, status_reg};
            dtc_pkg::IDX_IRQ_MASK:      rd_byte = {4'h0, mask_reg};
            default:                    rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= dtc_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, rd_byte};
            rresp  <= dtc_mapped(ar_idx) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    assign timer0_overflow_flag = control_reg[dtc_pkg::TC_TF0];
    assign timer1_overflow_flag = control_reg[dtc_pkg::TC_TF1];
    assign ext_irq0_flag        = control_reg[dtc_pkg::TC_IE0];
    assign ext_irq1_flag        = control_reg[dtc_pkg::TC_IE1];
endmodule
`default_nettype wire

//--- tb/dtc_assertions.sv
/* port checker for dtc_timer_top, bound to each instance.
   assumes one clock domain and the sync active-low reset */
`timescale 1ns/1ps
`default_nettype none
module dtc_chk (
    input wire logic        aclk,                 // clock
    input wire logic        aresetn,              // reset
    input wire logic        awready,              // aw ready
    input wire logic        wready,               // w ready
    input wire logic        bvalid,               // b valid
    input wire logic        bready,               // b ready
    input wire logic [1:0]  bresp,                // b resp
    input wire logic        arvalid,              // ar valid
    input wire logic        arready,              // ar ready
    input wire logic        rvalid,               // r valid
    input wire logic        rready,               // r ready
    input wire logic [31:0] rdata,                // r data
    input wire logic        ack_timer0,           // vector ack
    input wire logic        ack_timer1,           // vector ack
    input wire logic        timer0_overflow_flag, // flag
    input wire logic        timer1_overflow_flag, // flag
    input wire logic        ext_irq0_pin,         // pin
    input wire logic        ext_irq0_flag         // flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_W_BUSY: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    AST_AR_BUSY: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    AST_R_NEXT: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read upper bits set");
    AST_TF0_ACK: assert property (ack_timer0 |=> !timer0_overflow_flag)
        else $error("timer0 flag kept after ack");
    AST_TF1_ACK: assert property (ack_timer1 |=> !timer1_overflow_flag)
        else $error("timer1 flag kept after ack");
    // a software write may also set the flag, so that edge is excused
    AST_IE0_SET: assert property ($rose(ext_irq0_flag) && !$rose(bvalid) |->
        !$past(ext_irq0_pin, 2) || !$past(ext_irq0_pin, 3) || !$past(ext_irq0_pin, 4))
        else $error("ext irq0 flag without low pin");
endmodule
bind dtc_timer_top dtc_chk dtc_chk_i (.aclk, .aresetn, .awready, .wready, .bvalid, .bready,
    .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .ack_timer0, .ack_timer1,
    .timer0_overflow_flag, .timer1_overflow_flag, .ext_irq0_pin, .ext_irq0_flag);
`default_nettype wire

//--- tb/dtc_cpu_model.sv
/* cpu vectoring model: acknowledges pending flags whose vector is enabled.
   assumes the block drops a flag the cycle after its ack */
`timescale 1ns/1ps
`default_nettype none
module dtc_cpu_model (
    input  wire logic       aclk,    // clock
    input  wire logic       aresetn, // reset, active low
    input  wire logic [3:0] flags,   // ie1 ie0 tf1 tf0
    input  wire logic [3:0] enable,  // vectoring allowed
    output logic      [3:0] ack      // one-cycle pulses
);
    logic [3:0] seen_reg;
    // one cycle of latency stands in for the instruction boundary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_reg <= 4'h0;
            ack      <= 4'h0;
        end else begin
            seen_reg <= flags & enable & ~ack & ~seen_reg;
            ack      <= seen_reg;
        end
    end
endmodule
`default_nettype wire

//--- tb/test_dual_timer_counter_ext_irq.sv
/* bench for dtc_timer_top: axi4-lite master tasks, pin stimulus, cpu model.
   assumes the response timing of the design hand-over */
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_counter_ext_irq;
    localparam logic [11:0] A_TC  = {dtc_pkg::IDX_TIMER_CONTROL, 2'b00};
    localparam logic [11:0] A_TM  = {dtc_pkg::IDX_TIMER_MODE, 2'b00};
    localparam logic [11:0] A_TL0 = {dtc_pkg::IDX_TIMER0_LOW, 2'b00};
    localparam logic [11:0] A_TH0 = {dtc_pkg::IDX_TIMER0_HIGH, 2'b00};
    localparam logic [11:0] A_ST  = {dtc_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MK  = {dtc_pkg::IDX_IRQ_MASK, 2'b00};
    logic        aclk, awready, wready, bvalid, arready, rvalid;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000, rdata, rd_val;
    logic [3:0]  wstrb = 4'hF, ack_en = 4'h0, ack;
    logic [1:0]  bresp, rresp, last_resp, ext_pin = 2'b11, cnt_pin = 2'b11;
    logic [4:0]  flags;
    logic [2:0]  hs;
    logic [7:0]  tl;
    // mode, th, tl, high byte after wrap, low byte mask and value
    logic [47:0] tab [3] = '{48'h00FFFF00E0E0, 48'h01FFFE008000, 48'h0280FE808080};
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    dtc_timer_top dtc_timer_top_i (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .ext_irq0_pin(ext_pin[0]),
        .ext_irq1_pin(ext_pin[1]), .timer0_count_pin(cnt_pin[0]),
        .timer1_count_pin(cnt_pin[1]), .ack_timer0(ack[0]), .ack_timer1(ack[1]),
        .ack_ext_irq0(ack[2]), .ack_ext_irq1(ack[3]), .timer0_overflow_flag(flags[0]),
        .timer1_overflow_flag(flags[1]), .ext_irq0_flag(flags[2]),
        .ext_irq1_flag(flags[3]), .irq(flags[4]));
    dtc_cpu_model dtc_cpu_model_i (.aclk, .aresetn, .flags(flags[3:0]), .enable(ack_en), .ack);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end
    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is combinational: look mid-cycle, act at the following edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge aclk);
            hs = {awready, wready, bvalid};
            last_resp = bresp;
            @(posedge aclk);
            if (hs[2]) awvalid <= 1'b0;
            if (hs[1]) wvalid <= 1'b0;
        end while (!hs[0]);
    endtask
    task automatic rd(input logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            hs = {arready, 1'b0, rvalid};
            rd_val = rdata;
            last_resp = rresp;
            @(posedge aclk);
            if (hs[2]) arvalid <= 1'b0;
        end while (!hs[0]);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        rd(a);
        chk(rd_val, {24'h000000, e});
        chk(last_resp, r);
    endtask
    task automatic wait_hi(input int b);
        for (int n = 0; n < 300 && flags[b] !== 1'b1; n++) @(posedge aclk);
    endtask
    // low byte sits eight bytes below the matching high byte
    task automatic run_ovf(input int b, input logic [7:0] tm, input logic [11:0] tha,
                           input logic [7:0] th, input logic [7:0] tlv, input logic [7:0] tc);
        wr(A_TC, 8'h00);
        wr(A_TM, tm);
        wr(tha, th);
        wr(tha - 12'h008, tlv);
        ack_en <= 4'(1 << b);
        wr(A_TC, tc);
        wait_hi(b);
        chk(flags[b], 1'b1);
        repeat (4) @(posedge aclk);
        chk(flags[b], 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) rdc(A_TC + 12'(4 * i), 8'h00, 2'b00);
        rdc(12'h000, 8'h00, dtc_pkg::RESP_SLVERR);
        wr(12'h000, 8'h00);
        chk(last_resp, dtc_pkg::RESP_SLVERR);
        wr(A_TL0 + 12'h004, 8'h5A);
        rdc(A_TL0 + 12'h004, 8'h5A, dtc_pkg::RESP_OKAY);
        for (int j = 0; j < 3; j++) begin
            run_ovf(0, tab[j][47:40], A_TH0, tab[j][39:32], tab[j][31:24], 8'h10);
            wr(A_TC, 8'h00);
            rdc(A_TH0, tab[j][23:16], 2'b00);
            rd(A_TL0);
            tl = rd_val[7:0];
            chk(tl & tab[j][15:8], tab[j][7:0]);
            repeat (6) @(posedge aclk);
            rdc(A_TL0, tl, 2'b00);
        end
        for (int b = 0; b < 2; b++) begin
            wr(A_TM, b ? 8'h50 : 8'h05);
            wr(A_TL0 + 12'(4 * b), 8'h00);
            wr(A_TC, b ? 8'h40 : 8'h10);
            repeat (3) begin
                cnt_pin[b] <= 1'b0;
                repeat (4) @(posedge aclk);
                cnt_pin[b] <= 1'b1;
                repeat (4) @(posedge aclk);
            end
            rdc(A_TL0 + 12'(4 * b), 8'h03, 2'b00);
            wr(A_TM, b ? 8'h90 : 8'h09);
            ext_pin[b] <= 1'b0;
            repeat (6) @(posedge aclk);
            wr(A_TL0 + 12'(4 * b), 8'h00);
            repeat (20) @(posedge aclk);
            rdc(A_TL0 + 12'(4 * b), 8'h00, 2'b00);
            chk(flags[2 + b], 1'b1);
            ext_pin[b] <= 1'b1;
            repeat (20) @(posedge aclk);
            rd(A_TL0 + 12'(4 * b));
            chk(32'(rd_val[7:0] inside {[8'h08:8'h0A]}), 1);
            wr(A_TC, b ? 8'h04 : 8'h01);
            ext_pin[b] <= 1'b0;
            repeat (6) @(posedge aclk);
            ext_pin[b] <= 1'b1;
            repeat (6) @(posedge aclk);
            chk(flags[2 + b], 1'b1);
            ack_en <= 4'(4 << b);
            repeat (4) @(posedge aclk);
            chk(flags[2 + b], 1'b0);
        end
        run_ovf(1, 8'h10, A_TH0 + 12'h004, 8'hFF, 8'hFE, 8'h40);
        run_ovf(1, 8'h03, A_TH0, 8'hFF, 8'h00, 8'h40);
        run_ovf(0, 8'h03, A_TH0, 8'h00, 8'hFE, 8'h10);
        run_ovf(1, 8'h20, A_TH0 + 12'h004, 8'h80, 8'hFE, 8'h40);
        run_ovf(1, 8'h00, A_TH0 + 12'h004, 8'hFF, 8'hFF, 8'h40);
        wr(A_TM, 8'h30);
        wr(A_TL0 + 12'h004, 8'h07);
        wr(A_TC, 8'h40);
        repeat (10) @(posedge aclk);
        rdc(A_TL0 + 12'h004, 8'h07, 2'b00);
        wr(A_MK, 8'h00);
        rd(A_ST);
        run_ovf(0, 8'h01, A_TH0, 8'hFF, 8'hFE, 8'h10);
        wr(A_TC, 8'h00);
        chk(flags[4], 1'b0);
        wr(A_MK, 8'h01);
        wait_hi(4);
        chk(flags[4], 1'b1);
        rdc(A_ST, 8'h01, 2'b00);
        repeat (3) @(posedge aclk);
        chk(flags[4], 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
